// [verilog/urx_map.svh]
// Register offsets, field positions, reset values and timing for the receiver.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define URX_OFF_STAT   8'h00
`define URX_OFF_CTLB   8'h04
`define URX_OFF_CTLC   8'h08
`define URX_OFF_DATA   8'h0c
`define URX_OFF_BAUD   8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define URX_STAT_RXC   7
`define URX_STAT_FE    4
`define URX_STAT_DOR   3
`define URX_STAT_UPE   2
`define URX_STAT_U2X   1
`define URX_CTLB_RX_COMPLETE_IRQ_EN 7
`define URX_CTLB_RX_ENABLE  4
`define URX_CTLC_PEN   5
`define URX_CTLC_PODD  4
`define URX_CTLC_SBC   3
`define URX_CTLC_CSZ_H 2
`define URX_CTLC_CSZ_L 1

// ---------------------------------------------------------------
// Reset values and sampling figures
// ---------------------------------------------------------------
`define URX_BAUD_RST   16'h0019
`define URX_CTLC_RST   2'h3
`define URX_SPB_NORM   5'h10
`define URX_SPB_FAST   5'h08
`define URX_VF_NORM    5'h08
`define URX_VF_FAST    5'h04
`define URX_DEPTH      2'h2
`define URX_CNT_EDGE_NEXT 5'h2

`endif

// [verilog/urx_pkg.sv]
// Types shared by the receiver design.
// Assumes no other package.
`default_nettype none

package urx_pkg;
  // Receiver sequencing states
  typedef enum logic [2:0] {
    URX_IDLE  = 3'b000,
    URX_START = 3'b001,
    URX_DATA  = 3'b010,
    URX_PAR   = 3'b011,
    URX_STOP  = 3'b100
  } urx_state_t;
endpackage

`default_nettype wire

// [verilog/urx_receiver.sv]
// Serial receiver: start detect, bit voting, two-entry buffer, status flags.
// Assumes an APB master on pclk and an asynchronous line on rx_serial_in.
//
// Contract
// [R01] receive_complete set while buffer holds data
// [R02] Disabling receiver flushes the buffer
// [R03] Interrupt requested while flag and enables set
// [R04] Handler must read data to clear
// [R05] Error flags stored per entry, read advances
// [R06] Error flag writes ignored; software writes zero
// [R07] Read status before reading data register
// [R08] Error flags never raise interrupts
// [R09] frame_error mirrors first stop bit value
// [R10] Only first stop bit is checked
// [R11] Overrun when full, held frame, new start
// [R12] Overrun cleared on successful buffer transfer
// [R13] parity_error reads zero when checking off
// [R14] Parity checked only when enabled, odd/even
// [R15] Parity compared and stored with entry
// [R16] parity_error valid until data read
// [R17] Disable stops at once, releases pin
// [R18] Software flushes by reading until empty
// [R19] Sixteen or eight samples per bit
// [R20] Start search on falling edge, sample one
// [R21] Start voted on samples 8-10 or 4-6
// [R22] Majority high rejects start, else resync
// [R23] Unused upper data bits read zero
// [R24] Each bit decided by three-sample majority
// [R25] Transfer after first stop bit
// [R26] Serial input synchronised before use
// [R27] Frame held while buffer is full
//
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
`include "urx_map.svh"

module urx_receiver
  import urx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rx_serial_in,
  input  wire logic        global_irq_en,
  output logic             rx_irq,
  output logic             rx_pin_override
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic        rx_enable_r;
  logic        rx_complete_irq_en_r;
  logic        double_speed_r;
  logic        parity_enable_r;
  logic        parity_odd_select_r;
  logic        stop_bit_count_r;
  logic [1:0]  char_size_r;
  logic [15:0] baud_div_r;

  // APB decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit_stat = (paddr == `URX_OFF_STAT);
  wire hit_ctlb = (paddr == `URX_OFF_CTLB);
  wire hit_ctlc = (paddr == `URX_OFF_CTLC);
  wire hit_data = (paddr == `URX_OFF_DATA);
  wire hit_baud = (paddr == `URX_OFF_BAUD);
  wire mapped   = hit_stat | hit_ctlb | hit_ctlc | hit_data | hit_baud;
  wire wr_acc   = access & pwrite & mapped;

  // Zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Software-written settings steer the receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enable_r          <= 1'b0;
      rx_complete_irq_en_r <= 1'b0;
      double_speed_r       <= 1'b0;
      {parity_enable_r, parity_odd_select_r, stop_bit_count_r} <= 3'h0;
      char_size_r          <= `URX_CTLC_RST;
      baud_div_r           <= `URX_BAUD_RST;
    end else if (wr_acc) begin
      // Error flag positions are not writable
      if (hit_stat) double_speed_r <= pwdata[`URX_STAT_U2X]; // [R06]
      if (hit_ctlb) begin
        rx_complete_irq_en_r <= pwdata[`URX_CTLB_RX_COMPLETE_IRQ_EN];
        rx_enable_r          <= pwdata[`URX_CTLB_RX_ENABLE];
      end
      if (hit_ctlc) begin
        parity_enable_r     <= pwdata[`URX_CTLC_PEN];
        parity_odd_select_r <= pwdata[`URX_CTLC_PODD];
        stop_bit_count_r    <= pwdata[`URX_CTLC_SBC];
        char_size_r         <= pwdata[`URX_CTLC_CSZ_H:`URX_CTLC_CSZ_L];
      end
      if (hit_baud) baud_div_r <= pwdata[15:0];
    end
  end

  // Receiver owns the pin only while enabled
  assign rx_pin_override = rx_enable_r; // [R17]

  // ---------------------------------------------------------------
  // Line synchroniser and sample tick
  // ---------------------------------------------------------------
  logic        sync1_r;
  logic        rx_s_r;
  logic [15:0] div_cnt_r;

  // Two flops keep metastability away from voting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      rx_s_r  <= 1'b1;
    end else begin
      sync1_r <= rx_serial_in; // [R26]
      rx_s_r  <= sync1_r;
    end
  end

  // Oversampling tick, one per divisor period plus one
  wire        tick        = (div_cnt_r == 16'h0);
  wire [15:0] div_cnt_nxt = tick ? baud_div_r : div_cnt_r - 16'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_cnt_r <= 16'h0;
    else          div_cnt_r <= div_cnt_nxt;
  end

  // ---------------------------------------------------------------
  // Bit recovery sequencer
  // ---------------------------------------------------------------
  urx_state_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] vote_r, vote_nxt;
  logic       par_r, par_nxt;
  logic       prev_r;
  logic       frame_done;
  logic       stop_val;

  // Samples per bit and voting window by speed
  wire [4:0] spb        = double_speed_r ? `URX_SPB_FAST : `URX_SPB_NORM; // [R19]
  wire [4:0] vote_first = double_speed_r ? `URX_VF_FAST : `URX_VF_NORM; // [R21]
  wire [4:0] vote_last  = vote_first + 5'h2;
  wire       in_vote    = (cnt_r >= vote_first) && (cnt_r <= vote_last);
  wire       bit_val    = maj3({vote_r[1:0], rx_s_r}); // [R24]
  wire [2:0] last_bit   = 3'h4 + {1'b0, char_size_r};
  wire       start_evt  = rx_enable_r & tick & (st_r == URX_IDLE) & prev_r & ~rx_s_r;

  // Parity over data bits; even expects xor zero
  wire par_err = parity_enable_r & (^sh_r ^ par_r ^ parity_odd_select_r); // [R14] [R15]

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    vote_nxt   = vote_r;
    par_nxt    = par_r;
    frame_done = 1'b0;
    stop_val   = 1'b1;
    if (!rx_enable_r) begin
      st_nxt = URX_IDLE; // [R17]
    end else if (tick) begin
      if (st_r == URX_IDLE) begin
        // Falling edge: this sample is number one, so the next is two
        if (start_evt) begin // [R20]
          st_nxt  = URX_START;
          cnt_nxt = `URX_CNT_EDGE_NEXT; // [R20] [R21]
          sh_nxt  = 8'h0; // [R23]
        end
      end else begin
        cnt_nxt = cnt_r + 5'h1;
        if (in_vote) vote_nxt = {vote_r[1:0], rx_s_r};
        if (cnt_r == vote_last) begin
          case (st_r)
            URX_START: if (bit_val) st_nxt = URX_IDLE; // [R22]
            URX_DATA:  sh_nxt[bit_r] = bit_val;
            URX_PAR:   par_nxt = bit_val;
            URX_STOP: begin
              // Only the first stop bit matters; frees line early
              frame_done = 1'b1; // [R10] [R25]
              stop_val   = bit_val;
              st_nxt     = URX_IDLE;
            end
            default: st_nxt = URX_IDLE;
          endcase
        end
        // Bit boundary: timing re-anchored to each accepted start
        if (cnt_r == spb) begin
          cnt_nxt = 5'h1;
          case (st_r)
            URX_START: begin
              st_nxt  = URX_DATA; // [R22]
              bit_nxt = 3'h0;
            end
            URX_DATA: begin
              if (bit_r == last_bit)
                st_nxt = parity_enable_r ? URX_PAR : URX_STOP;
              else
                bit_nxt = bit_r + 3'h1;
            end
            URX_PAR: st_nxt = URX_STOP;
            default: st_nxt = st_r;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= URX_IDLE;
      cnt_r  <= 5'h0;
      bit_r  <= 3'h0;
      sh_r   <= 8'h0;
      vote_r <= 3'h7;
      par_r  <= 1'b0;
      prev_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      vote_r <= vote_nxt;
      par_r  <= par_nxt;
      if (tick) prev_r <= rx_s_r;
    end
  end

  // ---------------------------------------------------------------
  // Holding stage and two-entry buffer
  // ---------------------------------------------------------------
  logic [10:0] hold_r;
  logic        hold_valid_r;
  logic        dor_pend_r;
  logic [10:0] mem_r [0:1];
  logic        rd_ptr_r;
  logic [1:0]  count_r;

  wire buf_full = (count_r == `URX_DEPTH);
  wire pop      = access & ~pwrite & hit_data & (count_r != 2'h0); // [R05]
  wire push     = hold_valid_r & ~buf_full & rx_enable_r;
  wire wr_ptr   = rd_ptr_r ^ count_r[0];
  wire ovr_evt  = start_evt & buf_full & hold_valid_r; // [R11]

  // Entry layout: {upe, dor, fe, data}
  wire [10:0] frame_word = {par_err, 1'b0, ~stop_val, sh_r}; // [R09] [R16]

  // Held frame waits for space; overwritten only after an overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r       <= 11'h0;
      hold_valid_r <= 1'b0;
      dor_pend_r   <= 1'b0;
    end else if (!rx_enable_r) begin
      hold_valid_r <= 1'b0; // [R02]
      dor_pend_r   <= 1'b0;
    end else begin
      if (frame_done) hold_r <= frame_word;
      hold_valid_r <= frame_done | (hold_valid_r & ~push); // [R27]
      // Set wins over the clear made by a transfer
      dor_pend_r   <= ovr_evt | (dor_pend_r & ~push); // [R12]
    end
  end

  // Buffer storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else if (!rx_enable_r) begin
      count_r  <= 2'h0; // [R02]
    end else begin
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge pclk) begin
    if (push) mem_r[wr_ptr] <= {hold_r[10], dor_pend_r, hold_r[8:0]}; // [R05] [R12]
  end

  // ---------------------------------------------------------------
  // Status, read data and interrupt
  // ---------------------------------------------------------------
  wire [10:0] head       = mem_r[rd_ptr_r];
  wire        rx_cmpl    = (count_r != 2'h0); // [R01]
  wire        head_fe    = rx_cmpl & head[8];
  wire        head_dor   = rx_cmpl & head[9];
  wire        head_upe   = rx_cmpl & head[10] & parity_enable_r; // [R13]
  wire [7:0]  stat_word  = {rx_cmpl, 2'h0, head_fe, head_dor, head_upe,
                            double_speed_r, 1'b0};
  wire [7:0]  ctlb_word  = {rx_complete_irq_en_r, 2'h0, rx_enable_r, 4'h0};
  wire [7:0]  ctlc_word  = {2'h0, parity_enable_r, parity_odd_select_r,
                            stop_bit_count_r, char_size_r, 1'b0};
  wire [7:0]  data_word  = rx_cmpl ? head[7:0] : 8'h0;
  wire [31:0] rd_mux     = hit_stat ? {24'h0, stat_word} :
                           hit_ctlb ? {24'h0, ctlb_word} :
                           hit_ctlc ? {24'h0, ctlc_word} :
                           hit_data ? {24'h0, data_word} :
                           hit_baud ? {16'h0, baud_div_r} : 32'h0;

  // Read data captured in setup, before the pop moves the head
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                prdata <= 32'h0;
    else if (setup && !pwrite)   prdata <= rd_mux;
  end

  // Level request; error flags deliberately play no part
  assign rx_irq = rx_cmpl & rx_complete_irq_en_r & global_irq_en; // [R03] [R08]

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flush_on_off: assert property (!rx_enable_r |=> (count_r == 2'h0) && !hold_valid_r) // [R02]
    else $error("buffer not flushed when receiver disabled");
  a_irq_follows: assert property (rx_cmpl && rx_complete_irq_en_r && global_irq_en
    |-> rx_irq) // [R03]
    else $error("receive interrupt missing");
  a_no_err_irq: assert property ((count_r == 2'h0) |-> !rx_irq) // [R08]
    else $error("interrupt with empty buffer");
  a_upe_gated: assert property (!parity_enable_r |-> !stat_word[`URX_STAT_UPE]) // [R13]
    else $error("parity error visible while checking off");
  a_start_reject: assert property (tick && rx_enable_r && st_r == URX_START
    && cnt_r == vote_last && bit_val |=> st_r == URX_IDLE) // [R22]
    else $error("noisy start not rejected");
  a_overrun_set: assert property (ovr_evt |=> dor_pend_r) // [R11]
    else $error("overrun not recorded");
  a_hold_kept: assert property (rx_enable_r && hold_valid_r && buf_full && !pop
    && !frame_done |=> hold_valid_r && $stable(hold_r)) // [R27]
    else $error("held frame lost while buffer full");
  a_pop_advance: assert property (pop && !push && rx_enable_r
    |=> count_r == $past(count_r) - 2'h1) // [R05]
    else $error("read did not advance buffer");
  a_stop_exit: assert property (!rx_enable_r |=> st_r == URX_IDLE ##1 !frame_done) // [R17]
    else $error("receiver kept running when disabled");

  a_first_sample: assert property (start_evt |=> st_r == URX_START
    && cnt_r == `URX_CNT_EDGE_NEXT) // [R20]
    else $error("start edge not counted as sample one");

  a_overrun_clear: assert property (push && !ovr_evt |=> !dor_pend_r) // [R12]
    else $error("overrun pending not cleared by transfer");

  a_short_char: assert property (frame_done && char_size_r == 2'h0
    |-> sh_r[7:5] == 3'h0) // [R23]
    else $error("unused data bits not zero");

endmodule

`default_nettype wire

// [bench/urx_tx_model.sv]
// Remote serial transmitter that drives the receive line.
// Assumes the caller gives the bit length in pclk cycles.
`default_nettype none

module urx_tx_model (
  input  wire logic pclk,
  output var logic  line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle line rests high, so nothing reads as a start bit
  initial line = 1'b1;

  // Whole bit time, so all three centre samples agree
  task automatic put(input logic b, input int len);
    @(posedge pclk) line <= b;
    repeat (len - 1) @(posedge pclk);
  endtask

  // Start, data LSB first, optional parity, one stop, then idle
  task automatic send(input logic [7:0] d, input int nb, input int spb,
                      input logic pe, input logic pb, input logic stop);
    put(1'b0, spb);
    for (int i = 0; i < nb; i++) put(d[i], spb);
    if (pe) put(pb, spb);
    put(stop, spb);
    put(1'b1, 2 * spb);
  endtask

  // Short low pulse, then a long idle for any frame it starts
  task automatic glitch(input int len);
    put(1'b0, len);
    put(1'b1, 200);
  endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench: APB tasks plus a remote transmitter model.
// Assumes urx_map.svh on the include path and baud divisor 0.
`default_nettype none
`include "urx_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         LIMIT = 40000;
  localparam logic [7:0] A_ST  = `URX_OFF_STAT;
  localparam logic [7:0] A_CB  = `URX_OFF_CTLB;
  localparam logic [7:0] A_CC  = `URX_OFF_CTLC;
  localparam logic [7:0] A_DT  = `URX_OFF_DATA;
  localparam logic [7:0] A_BD  = `URX_OFF_BAUD;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_line, global_irq_en, rx_irq, rx_pin_override, errv, odd, bad, pb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  int          miscompares, checks_done, cyc, spb;

  urx_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_serial_in(rx_line), .global_irq_en(global_irq_en),
    .rx_irq(rx_irq), .rx_pin_override(rx_pin_override));
  urx_tx_model tx (.pclk(pclk), .line(rx_line));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Hang guard: a stuck wait still reaches the verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends once pready is high; the bench timeout catches a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Pins looked at mid-cycle, after the edge's updates land
  task automatic pins(input logic [1:0] exp);
    @(negedge pclk);
    chk({30'h0, rx_irq, rx_pin_override}, {30'h0, exp});
  endtask

  task automatic conclude();
    $display("counts: checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------
  // Tests
  // ------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; global_irq_en = 0; miscompares = 0; checks_done = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST, 32'h0);
    rd(A_CC, 32'h6);
    rd(A_BD, 32'h19);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    pins(2'b00);
    $display("test reset done");
    wr(A_BD, 32'h0);
    // Divider must drain its reset count before ticks run every cycle
    repeat (30) @(posedge pclk);
    wr(A_CB, 32'h90);
    global_irq_en <= 1'b1;
    pins(2'b01);
    tx.send(8'ha5, 8, 16, 1'b0, 1'b0, 1'b1);
    pins(2'b11);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'ha5);
    pins(2'b01);
    tx.send(8'h5a, 8, 16, 1'b0, 1'b0, 1'b1);
    global_irq_en <= 1'b0;
    pins(2'b01);
    global_irq_en <= 1'b1;
    wr(A_CB, 32'h10);
    pins(2'b01);
    wr(A_CB, 32'h90);
    pins(2'b11);
    rd(A_DT, 32'h5a);
    $display("test irq done");
    wr(A_CC, 32'he); // Two stop bits asked for; only the first is judged
    tx.send(8'h3c, 8, 16, 1'b0, 1'b0, 1'b0);
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h90);
    rd(A_DT, 32'h3c);
    pins(2'b01);
    tx.send(8'h3c, 8, 16, 1'b0, 1'b0, 1'b1);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'h3c);
    $display("test stop done");
    for (int i = 0; i < 4; i++) begin
      odd = i[1];
      bad = i[0];
      pb = (^8'h5b) ^ odd ^ bad;
      wr(A_CC, 32'h26 | {27'h0, odd, 4'h0});
      tx.send(8'h5b, 8, 16, 1'b1, pb, 1'b1);
      rd(A_ST, bad ? 32'h84 : 32'h80);
      rd(A_DT, 32'h5b);
    end
    tx.send(8'h5b, 8, 16, 1'b1, 1'b1, 1'b1);
    wr(A_CC, 32'h6);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'h5b);
    wr(A_CC, 32'h0);
    tx.send(8'hff, 5, 16, 1'b0, 1'b0, 1'b1);
    rd(A_DT, 32'h1f);
    wr(A_CC, 32'h6);
    $display("test parity done");
    // Half a bit of low fails the start vote; one sample more passes it
    for (int s = 0; s < 2; s++) begin
      spb = s ? 8 : 16;
      wr(A_ST, s ? 32'h2 : 32'h0);
      tx.glitch(spb / 2);
      rd(A_ST, s ? 32'h2 : 32'h0);
      tx.glitch(spb / 2 + 1);
      rd(A_ST, s ? 32'h82 : 32'h80);
      rd(A_DT, 32'hff);
      tx.send(8'hc3, 8, spb, 1'b0, 1'b0, 1'b1);
      rd(A_ST, s ? 32'h82 : 32'h80);
      rd(A_DT, 32'hc3);
    end
    wr(A_ST, 32'h0);
    $display("test speed done");
    for (int j = 0; j < 4; j++) tx.send(8'h10 | j[7:0], 8, 16, 1'b0, 1'b0, 1'b1);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'h10);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'h11);
    rd(A_ST, 32'h88);
    rd(A_DT, 32'h13);
    rd(A_ST, 32'h0);
    tx.send(8'h14, 8, 16, 1'b0, 1'b0, 1'b1);
    rd(A_ST, 32'h80);
    rd(A_DT, 32'h14);
    $display("test overrun done");
    tx.send(8'h21, 8, 16, 1'b0, 1'b0, 1'b1);
    fork
      tx.send(8'h22, 8, 16, 1'b0, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge pclk);
        wr(A_CB, 32'h0);
      end
    join
    pins(2'b00);
    rd(A_ST, 32'h0);
    wr(A_CB, 32'h90);
    rd(A_ST, 32'h0);
    $display("test disable done");
    conclude();
  end
endmodule

`default_nettype wire
